/* verilog/tbsi_cfg.svh */
// Constants for the terminal bus select and interrupt block.
`ifndef TBSI_CFG_SVH
`define TBSI_CFG_SVH
`define TBSI_SEL_KSTAT   2'h0
`define TBSI_SEL_KBUF    2'h1
`define TBSI_SEL_PSTAT   2'h2
`define TBSI_SEL_PBUF    2'h3
`define TBSI_TOP_REGION  5'h1F
`define TBSI_A_TOP       17:13
`define TBSI_A_STRAP     12:3
`define TBSI_A_SEL       2:1
`define TBSI_A_BYTE      0
`define TBSI_MODE_DATO   2'h2
`define TBSI_MODE_DATOB  2'h3
`define TBSI_G_IN        2
`define TBSI_G_LO        1
`define TBSI_G_HI        0
`define TBSI_BIT_FLAG    7
`define TBSI_BIT_ENA     6
`define TBSI_BIT_LOOP    2
`define TBSI_VEC_CHAN    2
`define TBSI_VEC_LOW     1:0
`define TBSI_BR_LEVEL    4
`define TBSI_BR_LOW      4
`define TBSI_CHAN_KEY    1'h0
`define TBSI_CHAN_PRN    1'h1
`endif

/* verilog/tbsi_pkg.sv */
// Types shared by the terminal bus select and interrupt block.
`default_nettype none
package tbsi_pkg;
    typedef enum logic [1:0] {TBSI_IDLE, TBSI_REQ, TBSI_ACK, TBSI_MASTER} tbsi_irq_e;
    typedef struct packed {
        logic [17:0] addr;
        logic [1:0]  ctrl;
        logic        msyn;
        logic [15:0] data;
        logic        init;
        logic        slave_ack_inhibit_n;
        logic        bg;
        logic        bbsy;
        logic        ssyn;
        logic        npr;
    } tbsi_bus_in_s;
    typedef struct packed {
        logic [15:0] data;
        logic        data_oe_n;
        logic        ssyn;
        logic [3:0]  br;
        logic        sack;
        logic        bbsy;
        logic        intr;
        logic        bg_out;
    } tbsi_bus_out_s;
    typedef struct packed {
        logic        key_strobe_n;
        logic [6:0]  key_data;
        logic        demand;
    } tbsi_term_in_s;
    typedef struct packed {
        logic        print_strobe;
        logic [6:0]  print_data;
    } tbsi_term_out_s;
    typedef struct packed {
        logic [9:0]  addr;
        logic [5:0]  vec;
        logic        npr_sample_option;
        logic        keybuf_bit7_strap;
    } tbsi_strap_s;
    typedef struct packed {
        tbsi_bus_in_s   bi1;
        tbsi_bus_in_s   bi2;
        tbsi_term_in_s  ti1;
        tbsi_term_in_s  ti2;
        tbsi_strap_s    sp1;
        tbsi_strap_s    sp2;
        logic           msyn_prev;
        logic           key_prev;
        logic           dem_prev;
        logic           key_char_done;
        logic           keyboard_irq_enable;
        logic [6:0]     kb_buf;
        logic           pr_ready;
        logic           printer_irq_enable;
        logic           loopback_test_bit;
        logic [1:0]     armed;
        logic           chan;
        tbsi_irq_e      irq;
        tbsi_bus_out_s  bo;
        tbsi_term_out_s to;
    } tbsi_state_s;
endpackage
`default_nettype wire

/* verilog/tbsi_ctrl.sv */
// Bus select, register file and two-channel vectored interrupt logic of the terminal controller.
`timescale 1ns/10ps
`default_nettype none
`include "tbsi_cfg.svh"

module tbsi_ctrl #(
    parameter int BR_LEVEL = `TBSI_BR_LEVEL
) (
    input  wire logic                     ref_clk,
    input  wire logic                     rstn,
    input  wire logic                     clk_en,
    input  wire tbsi_pkg::tbsi_bus_in_s   bus_i,
    input  wire tbsi_pkg::tbsi_term_in_s  term_i,
    input  wire tbsi_pkg::tbsi_strap_s    strap_i,
    output var  tbsi_pkg::tbsi_bus_out_s  bus_o,
    output var  tbsi_pkg::tbsi_term_out_s term_o
);

    // ********************************************************************
    // Constants and functions.
    // ********************************************************************

    localparam logic [3:0] BR_MASK = 4'(4'h1 << (BR_LEVEL - `TBSI_BR_LOW));

    function automatic logic [2:0] gate_of(
        input logic [1:0] mode,
        input logic       a0
    );
        logic [2:0] g;
        g = 3'h0;
        case (mode)
            `TBSI_MODE_DATO: begin
                g[`TBSI_G_LO] = 1'b1;
                g[`TBSI_G_HI] = 1'b1;
            end
            `TBSI_MODE_DATOB: begin
                g[`TBSI_G_LO] = ~a0;
                g[`TBSI_G_HI] = a0;
            end
            default: begin
                g[`TBSI_G_IN] = 1'b1;
            end
        endcase
        return g;
    endfunction

    function automatic logic addr_hit(
        input logic [17:0] a,
        input logic [9:0]  strap
    );
        return (a[`TBSI_A_TOP] == `TBSI_TOP_REGION) && (a[`TBSI_A_STRAP] == ~strap);
    endfunction

    function automatic logic [15:0] vector_of(
        input logic [5:0] v,
        input logic       chan
    );
        return {7'h00, v, chan, 2'h0};
    endfunction

    // ********************************************************************
    // State and decode.
    // ********************************************************************

    tbsi_pkg::tbsi_state_s st;
    tbsi_pkg::tbsi_state_s next_st;

    logic       msyn_rise;
    logic       hit;
    logic [2:0] gate;
    logic [1:0] sel;
    logic       rd_en;
    logic       wr_lo;
    logic       wr_hi;
    logic       wr_pbuf;
    logic       key_ev;
    logic       dem_ev;
    logic       req_k;
    logic       req_p;
    logic       want_k;
    logic       want_p;
    logic       chan_req;
    logic [7:0] rd_byte;

    assign msyn_rise = st.bi2.msyn & ~st.msyn_prev;
    assign hit       = msyn_rise & addr_hit(st.bi2.addr, st.sp2.addr);
    assign gate      = gate_of(st.bi2.ctrl, st.bi2.addr[`TBSI_A_BYTE]);
    assign sel       = st.bi2.addr[`TBSI_A_SEL];
    // A gate may be true with no select, so every action needs both.
    assign rd_en     = hit & gate[`TBSI_G_IN] & (sel != `TBSI_SEL_PBUF);
    assign wr_lo     = hit & gate[`TBSI_G_LO] & (sel != `TBSI_SEL_KBUF);
    // A high-byte write is answered except at the keyboard buffer, and changes nothing except at the printer buffer.
    assign wr_hi     = hit & gate[`TBSI_G_HI] & (sel != `TBSI_SEL_KBUF);
    assign wr_pbuf   = hit & (gate[`TBSI_G_LO] | gate[`TBSI_G_HI])
                       & (sel == `TBSI_SEL_PBUF);
    assign key_ev    = st.key_prev & ~st.ti2.key_strobe_n;
    assign dem_ev    = st.ti2.demand & ~st.dem_prev;
    assign req_k     = st.key_char_done & st.keyboard_irq_enable;
    assign req_p     = st.pr_ready & st.printer_irq_enable;
    assign want_k    = req_k & st.armed[`TBSI_CHAN_KEY];
    assign want_p    = req_p & st.armed[`TBSI_CHAN_PRN];
    assign chan_req  = (st.chan == `TBSI_CHAN_KEY) ? req_k : req_p;

    // Only the low byte holds state; the high byte always reads zero.
    always_comb begin
        rd_byte = 8'h00;
        if (sel == `TBSI_SEL_KSTAT) begin
            rd_byte[`TBSI_BIT_FLAG] = st.key_char_done;
            rd_byte[`TBSI_BIT_ENA]  = st.keyboard_irq_enable;
        end else if (sel == `TBSI_SEL_KBUF) begin
            rd_byte[`TBSI_BIT_FLAG] = st.sp2.keybuf_bit7_strap & ~st.loopback_test_bit;
            rd_byte[6:0]            = st.loopback_test_bit ? 7'h00 : st.kb_buf;
        end else if (sel == `TBSI_SEL_PSTAT) begin
            rd_byte[`TBSI_BIT_FLAG] = st.pr_ready;
            rd_byte[`TBSI_BIT_ENA]  = st.printer_irq_enable;
            rd_byte[`TBSI_BIT_LOOP] = st.loopback_test_bit;
        end
    end

    // ********************************************************************
    // Next state.
    // ********************************************************************

    always_comb begin
        next_st = st;
        // Pins pass two flops; only the second stage is read by logic.
        next_st.bi1       = bus_i;
        next_st.bi2       = st.bi1;
        next_st.ti1       = term_i;
        next_st.ti2       = st.ti1;
        next_st.sp1       = strap_i;
        next_st.sp2       = st.sp1;
        next_st.msyn_prev = st.bi2.msyn;
        next_st.key_prev  = st.ti2.key_strobe_n;
        next_st.dem_prev  = st.ti2.demand;
        next_st.to.print_strobe = 1'b0;
        next_st.bo.bg_out = st.bi2.bg & (st.irq == tbsi_pkg::TBSI_IDLE)
                            & ~want_k & ~want_p;

        if (st.bi2.init) begin
            // Initialize wipes flags and any bus ownership at once.
            next_st.key_char_done       = 1'b0;
            next_st.keyboard_irq_enable = 1'b0;
            next_st.pr_ready            = 1'b0;
            next_st.printer_irq_enable  = 1'b0;
            next_st.loopback_test_bit   = 1'b0;
            next_st.armed               = 2'h3;
            next_st.irq                 = tbsi_pkg::TBSI_IDLE;
            next_st.bo.br               = 4'h0;
            next_st.bo.sack             = 1'b0;
            next_st.bo.bbsy             = 1'b0;
            next_st.bo.intr             = 1'b0;
            next_st.bo.ssyn             = 1'b0;
            next_st.bo.data_oe_n        = 1'b1;
            next_st.bo.data             = 16'h0000;
        end else begin
            // Slave side: hold the answer until the master drops its sync.
            if (st.bo.ssyn && !st.bi2.msyn) begin
                next_st.bo.ssyn      = 1'b0;
                next_st.bo.data_oe_n = 1'b1;
                next_st.bo.data      = 16'h0000;
            end
            if ((rd_en || wr_lo || wr_hi) && st.bi2.slave_ack_inhibit_n) begin
                next_st.bo.ssyn = 1'b1;
            end
            if (rd_en && st.bi2.slave_ack_inhibit_n) begin
                next_st.bo.data      = {8'h00, rd_byte};
                next_st.bo.data_oe_n = 1'b0;
            end

            // Keyboard flag: reading the buffer clears it, an event in the
            // same cycle still sets it.
            if (rd_en && sel == `TBSI_SEL_KBUF) begin
                next_st.key_char_done = 1'b0;
            end
            if (key_ev) begin
                next_st.key_char_done = 1'b1;
                next_st.kb_buf        = st.ti2.key_data;
            end
            if (wr_pbuf && st.loopback_test_bit) begin
                next_st.key_char_done = 1'b1;
            end

            if (wr_lo && sel == `TBSI_SEL_KSTAT) begin
                next_st.keyboard_irq_enable = st.bi2.data[`TBSI_BIT_ENA];
            end
            if (wr_lo && sel == `TBSI_SEL_PSTAT) begin
                next_st.printer_irq_enable = st.bi2.data[`TBSI_BIT_ENA];
                next_st.loopback_test_bit  = st.bi2.data[`TBSI_BIT_LOOP];
            end

            // Printer buffer: any write strobes; a high-byte-only write
            // leaves the character unchanged since it has no high bits.
            if (wr_pbuf) begin
                next_st.pr_ready        = 1'b0;
                next_st.to.print_strobe = 1'b1;
                if (gate[`TBSI_G_LO]) begin
                    next_st.to.print_data = st.bi2.data[6:0];
                end
            end
            if (dem_ev) begin
                next_st.pr_ready = 1'b1;
            end

            // A channel re-arms only once its request has gone away.
            if (!req_k) begin
                next_st.armed[`TBSI_CHAN_KEY] = 1'b1;
            end
            if (!req_p) begin
                next_st.armed[`TBSI_CHAN_PRN] = 1'b1;
            end

            case (st.irq)
                tbsi_pkg::TBSI_IDLE: begin
                    if (want_k || want_p) begin
                        next_st.chan  = want_k ? `TBSI_CHAN_KEY : `TBSI_CHAN_PRN;
                        next_st.bo.br = BR_MASK;
                        next_st.irq   = tbsi_pkg::TBSI_REQ;
                    end
                end
                tbsi_pkg::TBSI_REQ: begin
                    if (!chan_req) begin
                        next_st.bo.br = 4'h0;
                        next_st.irq   = tbsi_pkg::TBSI_IDLE;
                    end else if (st.bi2.bg) begin
                        next_st.bo.br   = 4'h0;
                        next_st.bo.sack = 1'b1;
                        next_st.irq     = tbsi_pkg::TBSI_ACK;
                    end
                end
                tbsi_pkg::TBSI_ACK: begin
                    if (!st.bi2.bbsy && !st.bi2.ssyn && !st.bi2.bg) begin
                        next_st.bo.bbsy      = 1'b1;
                        next_st.bo.sack      = 1'b0;
                        next_st.bo.data      = vector_of(st.sp2.vec, st.chan);
                        next_st.bo.data_oe_n = 1'b0;
                        next_st.irq          = tbsi_pkg::TBSI_MASTER;
                    end
                end
                tbsi_pkg::TBSI_MASTER: begin
                    if (st.bo.intr && st.bi2.ssyn) begin
                        next_st.bo.bbsy       = 1'b0;
                        next_st.bo.intr       = 1'b0;
                        next_st.bo.data_oe_n  = 1'b1;
                        next_st.bo.data       = 16'h0000;
                        next_st.armed[st.chan] = 1'b0;
                        next_st.irq           = tbsi_pkg::TBSI_IDLE;
                    end else begin
                        // Only processor interrupts are made; a pending
                        // transfer request delays the interrupt if optioned.
                        next_st.bo.intr = st.bo.intr
                                          | ~(st.sp2.npr_sample_option & st.bi2.npr);
                    end
                end
                default: begin
                    next_st.irq = tbsi_pkg::TBSI_IDLE;
                end
            endcase
        end
    end

    // ********************************************************************
    // Registers.
    // ********************************************************************

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st              <= '0;
            st.bi1.msyn     <= 1'b0;
            st.bo.data_oe_n <= 1'b1;
            st.armed        <= 2'h3;
            st.key_prev     <= 1'b1;
            st.ti1.key_strobe_n <= 1'b1;
            st.ti2.key_strobe_n <= 1'b1;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign bus_o  = st.bo;
    assign term_o = st.to;

    // ********************************************************************
    // Checks.
    // ********************************************************************

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_live;
        clk_en && !st.bi2.init;
    endsequence

    sequence s_granted;
        s_live ##0 (st.irq == tbsi_pkg::TBSI_REQ) && chan_req && st.bi2.bg;
    endsequence

    sequence s_bus_free;
        s_live ##0 (st.irq == tbsi_pkg::TBSI_ACK) && !st.bi2.bbsy && !st.bi2.ssyn && !st.bi2.bg;
    endsequence

    sequence s_vector_taken;
        s_live ##0 (st.irq == tbsi_pkg::TBSI_MASTER) && st.bo.intr && st.bi2.ssyn;
    endsequence

    region_decode_a: assert property (
        $rose(bus_o.ssyn) |-> $past(st.bi2.addr[`TBSI_A_TOP]) == `TBSI_TOP_REGION)
        else $error("acknowledge outside the device region");

    ack_inhibit_a: assert property (
        clk_en && !st.bi2.slave_ack_inhibit_n && !st.bo.ssyn |=> !bus_o.ssyn)
        else $error("acknowledge given while inhibited");

    kb_enable_load_a: assert property (
        s_live ##0 (wr_lo && sel == `TBSI_SEL_KSTAT)
        |=> st.keyboard_irq_enable == $past(st.bi2.data[`TBSI_BIT_ENA])
            && $stable(st.printer_irq_enable))
        else $error("keyboard enable load wrong");

    key_done_set_a: assert property (
        s_live ##0 key_ev |=> st.key_char_done)
        else $error("key strobe did not set done");

    print_strobe_a: assert property (
        s_live ##0 wr_pbuf && !dem_ev |=> term_o.print_strobe ##1 !term_o.print_strobe)
        else $error("printer buffer write strobe wrong");

    grant_ack_a: assert property (
        s_granted |=> bus_o.sack && bus_o.br == 4'h0 && !bus_o.bbsy)
        else $error("grant not acknowledged");

    take_bus_a: assert property (
        s_bus_free |=> bus_o.bbsy && !bus_o.sack && !bus_o.data_oe_n)
        else $error("bus not taken when free");

    grant_pass_a: assert property (
        clk_en && st.irq == tbsi_pkg::TBSI_IDLE && !want_k && !want_p
        |=> bus_o.bg_out == $past(st.bi2.bg))
        else $error("idle grant not passed through");

    vector_bits_a: assert property (
        bus_o.intr |-> bus_o.data[`TBSI_VEC_CHAN] == st.chan
                       && bus_o.data[`TBSI_VEC_LOW] == 2'h0 && bus_o.bbsy)
        else $error("vector bits wrong");

    release_bus_a: assert property (
        s_vector_taken |=> !bus_o.bbsy && !bus_o.intr && !st.armed[st.chan])
        else $error("mastership not released");

    key_priority_a: assert property (
        s_live ##0 st.irq == tbsi_pkg::TBSI_IDLE && want_k && want_p
        |=> st.chan == `TBSI_CHAN_KEY && bus_o.br == BR_MASK)
        else $error("printer served before keyboard");

    npr_hold_a: assert property (
        s_live ##0 st.irq == tbsi_pkg::TBSI_MASTER && !st.bo.intr
        && st.sp2.npr_sample_option && st.bi2.npr |=> !bus_o.intr)
        else $error("interrupt completed under transfer request");

    init_clear_a: assert property (
        clk_en && st.bi2.init |=> !st.key_char_done && !st.pr_ready && !bus_o.bbsy
                                   && bus_o.br == 4'h0 && !st.loopback_test_bit)
        else $error("initialize left state behind");

    ready_set_a: assert property (
        s_live ##0 dem_ev |=> st.pr_ready)
        else $error("printer demand did not set ready");

    loop_done_a: assert property (
        s_live ##0 wr_pbuf && st.loopback_test_bit |=> st.key_char_done)
        else $error("loopback print did not set keyboard done");

    pr_enable_load_a: assert property (
        s_live ##0 (wr_lo && sel == `TBSI_SEL_PSTAT)
        |=> st.printer_irq_enable == $past(st.bi2.data[`TBSI_BIT_ENA])
            && $stable(st.keyboard_irq_enable))
        else $error("printer enable load wrong");

    high_byte_ack_a: assert property (
        s_live ##0 wr_hi && st.bi2.slave_ack_inhibit_n |=> bus_o.ssyn)
        else $error("high byte write not answered");

endmodule
`default_nettype wire

/* bench/tbsi_host.sv */
// Host processor and bus arbiter model facing the interrupt requester.
`timescale 1ns/10ps
`default_nettype none
module tbsi_host (
    input  wire logic                    ref_clk,
    input  wire logic                    rstn,
    input  wire logic                    hold,
    input  wire logic                    poke,
    input  wire tbsi_pkg::tbsi_bus_out_s bus_o,
    output var  logic                    bg,
    output var  logic                    ssyn,
    output var  int                      vcnt,
    output var  logic [15:0]             vlast
);
    // ****************************************
    // Grant and vector capture
    // ****************************************
    logic grant;
    assign bg = grant | poke;
    // The grant is held until acknowledged, so a slow requester still sees it.
    always @(negedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            grant <= 1'b0;
            ssyn <= 1'b0;
            vcnt <= 0;
            vlast <= 16'h0000;
        end else begin
            if ((|bus_o.br) && !bus_o.bbsy && !hold) grant <= 1'b1;
            if (bus_o.sack) grant <= 1'b0;
            if (bus_o.intr && !ssyn) begin
                vlast <= bus_o.data;
                vcnt <= vcnt + 1;
                ssyn <= 1'b1;
            end
            if (!bus_o.bbsy) ssyn <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* bench/tbsi_ctrl_tb.sv */
// Self-checking testbench of the terminal bus select and interrupt block.
`timescale 1ns/10ps
`default_nettype none
module tbsi_ctrl_tb;
    // ****************************************
    // Stimulus, tasks and tests
    // ****************************************
    localparam logic [17:0] BASE = 18'h3FF70;
    logic        ref_clk = 1'b0, rstn = 1'b0, ms = 1'b0, ini = 1'b0, inh_n = 1'b1;
    logic        npr = 1'b0, ks_n = 1'b1, dem = 1'b0, hold = 1'b0, poke = 1'b0, bg, hs;
    logic [17:0] ad = BASE;
    logic [1:0]  cm = 2'h0;
    logic [15:0] wd = 16'h0000, q, vl;
    logic [6:0]  kd = 7'h00, pd;
    int          vc, v, pc = 0, err_total = 0, comparisons = 0;
    tbsi_pkg::tbsi_bus_out_s  bo;
    tbsi_pkg::tbsi_term_out_s to;
    always #4 ref_clk = ~ref_clk;
    always @(negedge ref_clk) begin
        if (to.print_strobe) begin
            pc++;
            pd = to.print_data;
        end
    end
    tbsi_ctrl tbsi_ctrl_i (.ref_clk(ref_clk), .rstn(rstn), .clk_en(1'b1),
        .bus_i(tbsi_pkg::tbsi_bus_in_s'{addr:ad, ctrl:cm, msyn:ms, data:wd, init:ini,
            slave_ack_inhibit_n:inh_n, bg:bg, bbsy:bo.bbsy, ssyn:hs, npr:npr}),
        .term_i(tbsi_pkg::tbsi_term_in_s'{key_strobe_n:ks_n, key_data:kd, demand:dem}),
        .strap_i(tbsi_pkg::tbsi_strap_s'{addr:10'h011, vec:6'h06, npr_sample_option:1'b1,
            keybuf_bit7_strap:1'b1}), .bus_o(bo), .term_o(to));
    tbsi_host tbsi_host_i (.ref_clk(ref_clk), .rstn(rstn), .hold(hold), .poke(poke),
        .bus_o(bo), .bg(bg), .ssyn(hs), .vcnt(vc), .vlast(vl));
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic results();
        $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // Data is inverted once the strobe drops so a stale value cannot pass for a fresh one.
    task automatic cyc(input logic [17:0] a, input logic [1:0] c, input logic [15:0] d,
                       input logic ack);
        int n;
        step(1);
        ad = a;
        cm = c;
        wd = d;
        ms = 1'b1;
        n = 0;
        while (bo.ssyn !== 1'b1 && n < 12) begin
            step(1);
            n++;
        end
        q = bo.data;
        chk({15'h0, n < 12}, {15'h0, ack});
        ms = 1'b0;
        wd = ~d;
        while (bo.ssyn !== 1'b0 && n < 24) begin
            step(1);
            n++;
        end
        if (n >= 24) begin
            err_total++;
            results();
        end
    endtask
    task automatic rd(input logic [2:0] o, input logic [15:0] e);
        cyc(BASE + 18'(o), 2'h0, 16'h0000, 1'b1);
        chk(q, e);
    endtask
    task automatic wr(input logic [2:0] o, input logic [15:0] d);
        cyc(BASE + 18'(o), 2'h2, d, 1'b1);
    endtask
    task automatic key(input logic [6:0] d);
        step(1);
        kd = d;
        ks_n = 1'b0;
        step(2);
        ks_n = 1'b1;
        step(4);
    endtask
    task automatic pdem();
        dem = 1'b0;
        step(2);
        dem = 1'b1;
        step(4);
    endtask
    task automatic waitv(input int p);
        int n;
        n = 0;
        while (vc == p && n < 300) begin
            step(1);
            n++;
        end
        if (n == 300) begin
            err_total++;
            results();
        end
    endtask
    initial begin
        step(2);
        rstn = 1'b1;
        step(3);
        chk({15'h0, bo.data_oe_n}, 16'h0001);
        $display("test reset done");
        rd(3'h0, 16'h0000);
        wr(3'h0, 16'hFFFF);
        rd(3'h0, 16'h0040);
        rd(3'h4, 16'h0000);
        cyc(BASE + 18'h1, 2'h3, 16'h0000, 1'b1);
        rd(3'h0, 16'h0040);
        cyc(BASE, 2'h3, 16'h0000, 1'b1);
        rd(3'h0, 16'h0000);
        cyc(BASE + 18'h4, 2'h1, 16'h0000, 1'b1);
        cyc(BASE + 18'h6, 2'h0, 16'h0000, 1'b0);
        cyc(BASE + 18'h2, 2'h2, 16'h0000, 1'b0);
        cyc(BASE ^ 18'h20000, 2'h0, 16'h0000, 1'b0);
        cyc(BASE ^ 18'h00008, 2'h0, 16'h0000, 1'b0);
        cyc(BASE ^ 18'h00010, 2'h0, 16'h0000, 1'b0);
        inh_n = 1'b0;
        cyc(BASE, 2'h0, 16'h0000, 1'b0);
        inh_n = 1'b1;
        $display("test decode done");
        key(7'h55);
        rd(3'h0, 16'h0080);
        rd(3'h2, 16'h00D5);
        pdem();
        rd(3'h4, 16'h0080);
        v = pc;
        wr(3'h6, 16'h1241);
        chk({9'h0, pd}, 16'h0041);
        rd(3'h4, 16'h0000);
        cyc(BASE + 18'h7, 2'h3, 16'h4200, 1'b1);
        chk(16'(pc - v), 16'h0002);
        wr(3'h4, 16'h0004);
        rd(3'h4, 16'h0004);
        wr(3'h6, 16'h0033);
        wr(3'h4, 16'h0000);
        rd(3'h0, 16'h0080);
        rd(3'h2, 16'h00D5);
        $display("test registers done");
        poke = 1'b1;
        step(4);
        chk({15'h0, bo.bg_out}, 16'h0001);
        poke = 1'b0;
        wr(3'h0, 16'h0040);
        v = vc;
        key(7'h11);
        waitv(v);
        chk(vl, 16'h0030);
        step(40);
        chk(16'(vc - v), 16'h0001);
        wr(3'h0, 16'h0000);
        wr(3'h0, 16'h0040);
        waitv(v + 1);
        chk(vl, 16'h0030);
        hold = 1'b1;
        rd(3'h2, 16'h0091);
        v = vc;
        key(7'h22);
        pdem();
        wr(3'h4, 16'h0040);
        step(4);
        chk({12'h0, bo.br}, 16'h0001);
        hold = 1'b0;
        waitv(v);
        chk(vl, 16'h0030);
        waitv(v + 1);
        chk(vl, 16'h0034);
        rd(3'h2, 16'h00A2);
        wr(3'h4, 16'h0000);
        npr = 1'b1;
        v = vc;
        wr(3'h4, 16'h0040);
        step(60);
        chk(16'(vc - v), 16'h0000);
        npr = 1'b0;
        waitv(v);
        chk(vl, 16'h0034);
        $display("test interrupts done");
        ini = 1'b1;
        step(4);
        ini = 1'b0;
        step(4);
        rd(3'h0, 16'h0000);
        rd(3'h4, 16'h0000);
        $display("test init done");
        results();
    end
endmodule
`default_nettype wire
